// [design/shutter_timing_pkg.sv]
// Purpose: Constants and carrier types for the shutter timing register bank.
// Assumes: Byte registers on a 16-bit address space, one system clock.
package shutter_timing_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int NUM_REGS = 49;
	localparam logic [15:0] ROW_COUNT_HIGH_ADDR = 16'h3830;
	localparam logic [15:0] ROW_COUNT_LOW_ADDR = 16'h3831;
	localparam logic [15:0] REG_ADDR [NUM_REGS] = '{
		16'h380c, 16'h380d, 16'h382e, 16'h382f, 16'h3832, 16'h3833, 16'h3834, 16'h3835, 16'h3837,
		16'h3880, 16'h3881, 16'h3882, 16'h3883, 16'h3884, 16'h3885, 16'h3886, 16'h3887,
		16'h3888, 16'h3889, 16'h388a, 16'h388b, 16'h388c, 16'h388d, 16'h388e, 16'h388f,
		16'h3890, 16'h3891, 16'h3892, 16'h3893, 16'h3894, 16'h3895, 16'h3896, 16'h3897,
		16'h3898, 16'h3899, 16'h389a, 16'h389b, 16'h389c, 16'h389d, 16'h389e, 16'h389f,
		16'h38a0, 16'h38a1, 16'h38a2, 16'h38a3, 16'h38a4, 16'h38a5, 16'h38b1, 16'h38b5};
	localparam logic [7:0] REG_RESET [NUM_REGS] = '{
		8'h03, 8'h88, 8'h01, 8'h04, 8'h00, 8'h05, 8'h00, 8'h05, 8'h00,
		8'h10, 8'h44, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h15,
		8'h44, 8'h04, 8'h00, 8'h50, 8'h44, 8'h04, 8'h00, 8'h50,
		8'h04, 8'h44, 8'h00, 8'hf0, 8'h20, 8'h00, 8'h00, 8'h10,
		8'h30, 8'h01, 8'h01, 8'h00, 8'h44, 8'h00, 8'h00, 8'h3c,
		8'h44, 8'h05, 8'h00, 8'h10, 8'h10, 8'h00, 8'h02, 8'h00};
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{
		8'hff, 8'hff, 8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff,
		8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'h33, 8'h8f, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h0f, 8'h31};

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam int IDX_LINE_LEN_HIGH = 0;
	localparam int IDX_LINE_LEN_LOW = 1;
	localparam int IDX_LINE_SYNC = 2;
	localparam int IDX_BLANK_CFG = 3;
	localparam int IDX_START_HIGH = 4;
	localparam int IDX_START_LOW = 5;
	localparam int IDX_END_HIGH = 6;
	localparam int IDX_END_LOW = 7;
	localparam int IDX_DOWNSCALE = 8;
	localparam int IDX_PRE_EXPOSURE = 9;
	localparam int IDX_RAMP = 10;
	localparam int IDX_XFER_FORCE_HIGH = 29;
	localparam int IDX_XFER_FORCE_LOW = 30;
	localparam int IDX_PRECHARGE_MODE = 33;
	localparam int IDX_COL_LINE = 34;
	localparam int IDX_PRE_FORCE_HIGH = 45;
	localparam int IDX_PRE_FORCE_LOW = 46;
	localparam int IDX_COMBO = 47;
	localparam int IDX_STORAGE_GATE = 48;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_SPLIT_SEL = 2;
	localparam int BIT_TIMING_SYNC = 1;
	localparam int BIT_BLACK_SYNC = 0;
	localparam int BIT_START_OPT = 7;
	localparam int BIT_END_OPT = 6;
	localparam int BIT_ANA_TO_SYS = 5;
	localparam int BIT_SYS_TO_ANA = 4;
	localparam int BIT_RAMP_NEG = 0;
	localparam int BIT_NONOVERLAP = 5;
	localparam int BIT_LINE_MODE = 4;
	localparam int BIT_COL_STOP = 7;
	localparam int BIT_EDGE_OPT = 5;
	localparam int BIT_FORCE_ZERO = 4;
	localparam int BIT_SECOND_PULSE = 0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic writeEn;
		logic [7:0] writeData;
		logic readEn;
	} reg_req_t;

	typedef struct packed {
		logic rowAdvance;
		logic frameStart;
		logic [15:0] autoBlankStart;
		logic [15:0] autoBlankEnd;
		logic globalTransfer;
		logic [15:0] transferLineLength;
		logic timingLineStrobe;
		logic blackLineStrobe;
		logic imageLineStart;
		logic rampActive;
		logic storageGateRaw;
	} timing_in_t;

	typedef struct packed {
		logic [15:0] rowCount;
		logic [15:0] lineLength;
		logic timingStrobe;
		logic blackStrobe;
		logic systemPowerSave;
		logic analogPowerSave;
		logic rampEnable;
		logic storageGate;
	} timing_out_t;

	typedef struct packed {
		logic downscaleEnable;
		logic downscaleSum;
		logic downscaleBin;
		logic downscaleManual;
		logic downscale_mono;
		logic [3:0] framePrechargeOffset;
		logic [3:0] linePrechargeOffset;
		logic [7:0] transferForceHigh;
		logic [7:0] transferForceLow;
		logic [6:0] prechargeForceHigh;
		logic [6:0] prechargeForceLow;
		logic exposureNonOverlap;
		logic linePrechargeMode;
		logic [1:0] prechargeStartOpt;
		logic columnLineStop;
		logic [3:0] columnLineAhead;
		logic [1:0] gate_source_combo_sel;
		logic [1:0] gate_combo_sel;
		logic storage_gate_edge_option;
		logic storageGateSecondPulse;
	} shutter_cfg_t;

endpackage

// [design/shutter_timing_ctrl_bank.sv]
// Purpose: Row timing and global-shutter configuration bank with row counter and window logic.
// Assumes: The serial control decoder presents byte accesses on a 16-bit address, one cycle each.
// Notes: Read data appears one cycle after the read strobe and holds until the next read.
`timescale 1ns/100ps
`default_nettype none
module shutter_timing_ctrl_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register access from the control decoder
	input wire shutter_timing_pkg::reg_req_t regReq,
	output logic [7:0] regReadData,
	// Timing engine side
	input wire shutter_timing_pkg::timing_in_t timingIn,
	output shutter_timing_pkg::timing_out_t timingOut,
	output shutter_timing_pkg::shutter_cfg_t shutterCfg
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [shutter_timing_pkg::NUM_REGS-1:0][7:0] regs;
		logic [15:0] rowCount;
		logic [7:0] readData;
		logic timingAligned;
		logic blackAligned;
		shutter_timing_pkg::timing_out_t outs;
	} state_t;

	state_t state_q;
	state_t state_d;
	logic hit;
	logic [5:0] hitIdx;
	logic [7:0] ctrl;
	logic [7:0] blankCfg;
	logic [15:0] manualStart;
	logic [15:0] manualEnd;
	logic [15:0] startRow;
	logic [15:0] endRow;
	logic [15:0] rowOffset;
	logic innerWin;
	logic outerWin;
	logic analogWin;
	logic systemWin;
	logic [7:0] sgReg;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	always_comb begin
		hit = 1'b0;
		hitIdx = 6'h00;
		for (int i = 0; i < shutter_timing_pkg::NUM_REGS; i++) begin
			if (regReq.addr == shutter_timing_pkg::REG_ADDR[i]) begin
				hit = 1'b1;
				hitIdx = 6'(i);
			end
		end
	end

	// ----------------------------------------------------------------
	// Power-save window
	// ----------------------------------------------------------------
	always_comb begin
		ctrl = state_q.regs[shutter_timing_pkg::IDX_LINE_SYNC];
		blankCfg = state_q.regs[shutter_timing_pkg::IDX_BLANK_CFG];
		manualStart = {state_q.regs[shutter_timing_pkg::IDX_START_HIGH],
			state_q.regs[shutter_timing_pkg::IDX_START_LOW]};
		manualEnd = {state_q.regs[shutter_timing_pkg::IDX_END_HIGH],
			state_q.regs[shutter_timing_pkg::IDX_END_LOW]};
		rowOffset = {12'h000, blankCfg[3:0]};
		startRow = blankCfg[shutter_timing_pkg::BIT_START_OPT] ? manualStart :
			16'(timingIn.autoBlankStart + rowOffset);
		endRow = blankCfg[shutter_timing_pkg::BIT_END_OPT] ? manualEnd :
			16'(timingIn.autoBlankEnd - rowOffset);
		innerWin = (state_q.rowCount >= startRow) && (state_q.rowCount < endRow);
		outerWin = (state_q.rowCount >= timingIn.autoBlankStart) && (state_q.rowCount < timingIn.autoBlankEnd);
		analogWin = blankCfg[shutter_timing_pkg::BIT_ANA_TO_SYS] ? innerWin : (outerWin | innerWin);
		systemWin = blankCfg[shutter_timing_pkg::BIT_SYS_TO_ANA] ? analogWin : (innerWin & analogWin);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		if (regReq.writeEn && hit) begin
			state_d.regs[hitIdx] = regReq.writeData & shutter_timing_pkg::REG_MASK[hitIdx];
		end
		if (timingIn.frameStart) begin
			state_d.rowCount = 16'h0000;
		end else if (timingIn.rowAdvance) begin
			state_d.rowCount = 16'(state_q.rowCount + 16'h0001);
		end
		if (regReq.readEn) begin
			if (regReq.addr == shutter_timing_pkg::ROW_COUNT_HIGH_ADDR) begin
				state_d.readData = state_q.rowCount[15:8];
			end else if (regReq.addr == shutter_timing_pkg::ROW_COUNT_LOW_ADDR) begin
				state_d.readData = state_q.rowCount[7:0];
			end else if (hit) begin
				state_d.readData = state_q.regs[hitIdx] & shutter_timing_pkg::REG_MASK[hitIdx];
			end else begin
				state_d.readData = 8'h00;
			end
		end
		state_d.timingAligned = timingIn.timingLineStrobe & (timingIn.imageLineStart | state_q.timingAligned);
		state_d.blackAligned = timingIn.blackLineStrobe & (timingIn.imageLineStart | state_q.blackAligned);
		state_d.outs.rowCount = state_q.rowCount;
		state_d.outs.lineLength = (ctrl[shutter_timing_pkg::BIT_SPLIT_SEL] && timingIn.globalTransfer) ?
			timingIn.transferLineLength :
			{state_q.regs[shutter_timing_pkg::IDX_LINE_LEN_HIGH], state_q.regs[shutter_timing_pkg::IDX_LINE_LEN_LOW]};
		state_d.outs.timingStrobe = ctrl[shutter_timing_pkg::BIT_TIMING_SYNC] ?
			state_d.timingAligned : timingIn.timingLineStrobe;
		state_d.outs.blackStrobe = ctrl[shutter_timing_pkg::BIT_BLACK_SYNC] ?
			state_d.blackAligned : timingIn.timingLineStrobe;
		state_d.outs.systemPowerSave = systemWin;
		state_d.outs.analogPowerSave = analogWin;
		state_d.outs.rampEnable = timingIn.rampActive ^
			state_q.regs[shutter_timing_pkg::IDX_RAMP][shutter_timing_pkg::BIT_RAMP_NEG];
		state_d.outs.storageGate = timingIn.storageGateRaw &
			~state_q.regs[shutter_timing_pkg::IDX_STORAGE_GATE][shutter_timing_pkg::BIT_FORCE_ZERO];
		if (reset) begin
			for (int i = 0; i < shutter_timing_pkg::NUM_REGS; i++) begin
				state_d.regs[i] = shutter_timing_pkg::REG_RESET[i];
			end
			state_d.rowCount = 16'h0000;
			state_d.readData = 8'h00;
			state_d.timingAligned = 1'b0;
			state_d.blackAligned = 1'b0;
			state_d.outs = '0;
		end
	end

	always_ff @(posedge clk) begin
		state_q <= state_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign regReadData = state_q.readData;
	assign timingOut = state_q.outs;
	assign sgReg = state_q.regs[shutter_timing_pkg::IDX_STORAGE_GATE];

	always_comb begin
		shutterCfg.downscaleEnable = state_q.regs[shutter_timing_pkg::IDX_DOWNSCALE][0];
		shutterCfg.downscaleSum = state_q.regs[shutter_timing_pkg::IDX_DOWNSCALE][1];
		shutterCfg.downscaleBin = state_q.regs[shutter_timing_pkg::IDX_DOWNSCALE][2];
		shutterCfg.downscaleManual = state_q.regs[shutter_timing_pkg::IDX_DOWNSCALE][3];
		shutterCfg.downscale_mono = state_q.regs[shutter_timing_pkg::IDX_DOWNSCALE][4];
		shutterCfg.framePrechargeOffset = state_q.regs[shutter_timing_pkg::IDX_PRE_EXPOSURE][7:4];
		shutterCfg.linePrechargeOffset = state_q.regs[shutter_timing_pkg::IDX_PRE_EXPOSURE][3:0];
		shutterCfg.transferForceHigh = state_q.regs[shutter_timing_pkg::IDX_XFER_FORCE_HIGH];
		shutterCfg.transferForceLow = state_q.regs[shutter_timing_pkg::IDX_XFER_FORCE_LOW];
		shutterCfg.prechargeForceHigh = state_q.regs[shutter_timing_pkg::IDX_PRE_FORCE_HIGH][6:0];
		shutterCfg.prechargeForceLow = state_q.regs[shutter_timing_pkg::IDX_PRE_FORCE_LOW][6:0];
		shutterCfg.exposureNonOverlap =
			state_q.regs[shutter_timing_pkg::IDX_PRECHARGE_MODE][shutter_timing_pkg::BIT_NONOVERLAP];
		shutterCfg.linePrechargeMode =
			state_q.regs[shutter_timing_pkg::IDX_PRECHARGE_MODE][shutter_timing_pkg::BIT_LINE_MODE];
		shutterCfg.prechargeStartOpt = state_q.regs[shutter_timing_pkg::IDX_PRECHARGE_MODE][1:0];
		shutterCfg.columnLineStop = state_q.regs[shutter_timing_pkg::IDX_COL_LINE][shutter_timing_pkg::BIT_COL_STOP];
		shutterCfg.columnLineAhead = state_q.regs[shutter_timing_pkg::IDX_COL_LINE][3:0];
		shutterCfg.gate_source_combo_sel = state_q.regs[shutter_timing_pkg::IDX_COMBO][3:2];
		shutterCfg.gate_combo_sel = state_q.regs[shutter_timing_pkg::IDX_COMBO][1:0];
		shutterCfg.storage_gate_edge_option = sgReg[shutter_timing_pkg::BIT_EDGE_OPT];
		shutterCfg.storageGateSecondPulse = sgReg[shutter_timing_pkg::BIT_SECOND_PULSE];
	end

endmodule
`default_nettype wire

// [testbench/host_model.sv]
// Purpose: Host side of the register bus, one byte access at a time.
// Assumes: Requests change after the falling edge and are taken at the next rising edge.
// Notes: Idle address and data show inverted values so stale bytes are never mistaken for live ones.
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// Clock
	input wire logic clk,
	// Register bus
	output var shutter_timing_pkg::reg_req_t regReq,
	input wire logic [7:0] regReadData
);
	initial begin
		regReq = '0;
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		regReq = '{addr: a, writeEn: 1'b1, writeData: d, readEn: 1'b0};
		@(negedge clk);
		regReq = '{addr: ~a, writeEn: 1'b0, writeData: ~d, readEn: 1'b0};
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		regReq = '{addr: a, writeEn: 1'b0, writeData: 8'h00, readEn: 1'b1};
		@(negedge clk);
		d = regReadData;
		regReq = '{addr: ~a, writeEn: 1'b0, writeData: 8'hff, readEn: 1'b0};
	endtask
endmodule
`default_nettype wire

// [testbench/shutter_timing_ctrl_bank_assertions.sv]
// Purpose: Port-level checks for the shutter timing register bank.
// Assumes: Sees only the top ports; mirrors a few registers from bus writes.
// Notes: Timing outputs are compared with inputs and mirrored state one cycle earlier; the row count with inputs two cycles earlier.
`timescale 1ns/100ps
`default_nettype none
module shutter_timing_ctrl_bank_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register bus and timing side
	input wire shutter_timing_pkg::reg_req_t regReq,
	input wire logic [7:0] regReadData,
	input wire shutter_timing_pkg::timing_in_t timingIn,
	input wire shutter_timing_pkg::timing_out_t timingOut,
	input wire shutter_timing_pkg::shutter_cfg_t shutterCfg
);
	logic [2:0] syncSel_q;
	logic rampNeg_q;
	logic forceZero_q;
	logic [15:0] lineLen_q;
	// ----------------------------------------------------------------
	// Register mirrors
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			syncSel_q <= 3'h1;
			rampNeg_q <= 1'b0;
			forceZero_q <= 1'b0;
			lineLen_q <= 16'h0388;
		end else if (regReq.writeEn) begin
			case (regReq.addr)
				16'h380c: lineLen_q[15:8] <= regReq.writeData;
				16'h380d: lineLen_q[7:0] <= regReq.writeData;
				16'h382e: syncSel_q <= regReq.writeData[2:0];
				16'h3881: rampNeg_q <= regReq.writeData[0];
				16'h38b5: forceZero_q <= regReq.writeData[4];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence s_write_start;
		regReq.writeEn && regReq.addr == 16'h3833;
	endsequence
	sequence s_read_back;
		regReq.readEn && !regReq.writeEn && regReq.addr == 16'h3833;
	endsequence
	sequence s_gap;
		!(regReq.writeEn && regReq.addr == 16'h3833);
	endsequence
	a_write_read: assert property (s_write_start ##1 s_gap ##1 s_read_back |=> regReadData == $past(regReq.writeData, 3))
		else $error("start row byte did not read back");
	a_row_step: assert property (timingIn.rowAdvance && !timingIn.frameStart |-> ##2 timingOut.rowCount == $past(timingOut.rowCount) + 16'h1)
		else $error("row count did not advance by one");
	a_frame_clear: assert property (timingIn.frameStart |-> ##2 timingOut.rowCount == 16'h0)
		else $error("row count not cleared by frame start");
	a_count_high: assert property (regReq.readEn && regReq.addr == 16'h3830 |=> regReadData == timingOut.rowCount[15:8])
		else $error("row counter high byte mismatch");
	a_ramp_pol: assert property (!$past(reset) |-> timingOut.rampEnable == ($past(timingIn.rampActive) ^ $past(rampNeg_q)))
		else $error("ramp enable polarity wrong");
	a_black_raw: assert property (!$past(reset) && !$past(syncSel_q[0]) |-> timingOut.blackStrobe == $past(timingIn.timingLineStrobe))
		else $error("black strobe not the raw timing strobe");
	a_gate_force: assert property (!$past(reset) |-> timingOut.storageGate == ($past(timingIn.storageGateRaw) && !$past(forceZero_q)))
		else $error("storage gate force zero not applied");
	a_line_len: assert property (!$past(reset) |-> timingOut.lineLength == (($past(syncSel_q[2]) && $past(timingIn.globalTransfer)) ? $past(timingIn.transferLineLength) : $past(lineLen_q)))
		else $error("line length source wrong");
endmodule
bind shutter_timing_ctrl_bank shutter_timing_ctrl_bank_assertions shutter_timing_ctrl_bank_assertions_inst (.clk(clk),
	.reset(reset), .regReq(regReq), .regReadData(regReadData), .timingIn(timingIn), .timingOut(timingOut),
	.shutterCfg(shutterCfg));
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the shutter timing register bank.
// Assumes: Inputs change on the falling edge; host model drives the register bus.
// Notes: Random bytes come from a fixed-seed shift register.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk;
	logic reset;
	shutter_timing_pkg::reg_req_t regReq;
	logic [7:0] regReadData;
	shutter_timing_pkg::timing_in_t tIn;
	shutter_timing_pkg::timing_out_t tOut;
	shutter_timing_pkg::shutter_cfg_t cfg;
	int fails;
	int comparisons;
	int cycles;
	logic [15:0] lfsr;
	logic [7:0] rdata;
	logic [7:0] psCfg [3] = '{8'h04, 8'hc3, 8'h34};
	shutter_timing_ctrl_bank shutter_timing_ctrl_bank_inst (.clk(clk), .reset(reset), .regReq(regReq),
		.regReadData(regReadData), .timingIn(tIn), .timingOut(tOut), .shutterCfg(cfg));
	host_model host_model_inst (.clk(clk), .regReq(regReq), .regReadData(regReadData));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] nextRand(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Expected {analog, system} power-save levels for one row.
	function automatic logic [1:0] expPs(input logic [15:0] row, input logic [7:0] c, input logic [15:0] ms,
		input logic [15:0] me, input logic [15:0] as, input logic [15:0] ae);
		logic [15:0] st;
		logic [15:0] en;
		logic inner;
		logic ana;
		st = c[7] ? ms : as + 16'(c[3:0]);
		en = c[6] ? me : ae - 16'(c[3:0]);
		inner = row >= st && row < en;
		ana = c[5] ? inner : (inner || (row >= as && row < ae));
		return {ana, c[4] ? ana : (inner && ana)};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
		host_model_inst.rd(a, rdata);
		chk({8'h00, rdata}, {8'h00, e});
	endtask
	task automatic step(input logic adv, input logic fs);
		@(negedge clk);
		tIn.rowAdvance = adv;
		tIn.frameStart = fs;
		@(negedge clk);
		tIn.rowAdvance = 1'b0;
		tIn.frameStart = 1'b0;
		@(negedge clk);
	endtask
	task automatic settle();
		repeat (2) @(negedge clk);
	endtask
	// ----------------------------------------------------------------
	// Clock, timeout and sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		reset = 1'b1;
		tIn = '0;
		fails = 0;
		comparisons = 0;
		cycles = 0;
		lfsr = 16'hea40;
		tIn.autoBlankStart = 16'h000a;
		tIn.autoBlankEnd = 16'h001e;
		repeat (16) @(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < shutter_timing_pkg::NUM_REGS; i++) begin
			rdChk(shutter_timing_pkg::REG_ADDR[i], shutter_timing_pkg::REG_RESET[i]);
		end
		chk(16'(cfg.columnLineAhead), 16'h1);
		chk(16'(cfg.gate_combo_sel), 16'h2);
		chk(16'(cfg.transferForceHigh), 16'h20);
		chk(16'(cfg.prechargeForceHigh), 16'h10);
		for (int i = 0; i < shutter_timing_pkg::NUM_REGS; i++) begin
			lfsr = nextRand(lfsr);
			host_model_inst.wr(shutter_timing_pkg::REG_ADDR[i], lfsr[7:0]);
			rdChk(shutter_timing_pkg::REG_ADDR[i], lfsr[7:0] & shutter_timing_pkg::REG_MASK[i]);
		end
		reset = 1'b1;
		settle();
		reset = 1'b0;
		host_model_inst.wr(16'h3833, 8'h03);
		host_model_inst.wr(16'h3835, 8'h19);
		rdChk(16'h3835, 8'h19);
		for (int k = 0; k < 3; k++) begin
			host_model_inst.wr(16'h382f, psCfg[k]);
			step(1'b0, 1'b1);
			for (int r = 0; r < 32; r++) begin
				chk(tOut.rowCount, 16'(r));
				chk(16'(expPs(16'(r), psCfg[k], 16'h3, 16'h19, 16'ha, 16'h1e)), 16'({tOut.analogPowerSave, tOut.systemPowerSave}));
				step(1'b1, 1'b0);
			end
		end
		host_model_inst.wr(16'h3831, 8'hff);
		rdChk(16'h3831, 8'h20);
		rdChk(16'h3830, 8'h00);
		rdChk(16'h3836, 8'h00);
		tIn.transferLineLength = 16'habcd;
		tIn.globalTransfer = 1'b1;
		host_model_inst.wr(16'h380c, 8'h12);
		host_model_inst.wr(16'h380d, 8'h34);
		settle();
		chk(tOut.lineLength, 16'h1234);
		host_model_inst.wr(16'h382e, 8'h04);
		settle();
		chk(tOut.lineLength, 16'habcd);
		tIn.timingLineStrobe = 1'b1;
		tIn.blackLineStrobe = 1'b1;
		settle();
		chk(16'({tOut.timingStrobe, tOut.blackStrobe}), 16'h3);
		host_model_inst.wr(16'h382e, 8'h03);
		settle();
		chk(16'({tOut.timingStrobe, tOut.blackStrobe}), 16'h0);
		tIn.imageLineStart = 1'b1;
		settle();
		chk(16'({tOut.timingStrobe, tOut.blackStrobe}), 16'h3);
		tIn.rampActive = 1'b1;
		tIn.storageGateRaw = 1'b1;
		host_model_inst.wr(16'h3881, 8'h45);
		host_model_inst.wr(16'h38b5, 8'h10);
		settle();
		chk(16'({tOut.rampEnable, tOut.storageGate}), 16'h0);
		host_model_inst.wr(16'h3881, 8'h44);
		host_model_inst.wr(16'h38b5, 8'h21);
		settle();
		chk(16'({tOut.rampEnable, tOut.storageGate, cfg.storage_gate_edge_option, cfg.storageGateSecondPulse}), 16'hf);
		host_model_inst.wr(16'h3837, 8'h15);
		chk(16'({cfg.downscale_mono, cfg.downscaleManual, cfg.downscaleBin, cfg.downscaleSum, cfg.downscaleEnable}), 16'h15);
		host_model_inst.wr(16'h3898, 8'h21);
		chk(16'({cfg.exposureNonOverlap, cfg.linePrechargeMode, cfg.prechargeStartOpt}), 16'h9);
		host_model_inst.wr(16'h38b1, 8'h0d);
		chk(16'({cfg.gate_source_combo_sel, cfg.gate_combo_sel}), 16'hd);
		host_model_inst.wr(16'h3880, 8'ha5);
		chk(16'({cfg.framePrechargeOffset, cfg.linePrechargeOffset}), 16'ha5);
		host_model_inst.wr(16'h38a5, 8'hff);
		chk(16'(cfg.prechargeForceLow), 16'h7f);
		host_model_inst.wr(16'h3895, 8'h81);
		chk(16'(cfg.transferForceLow), 16'h81);
		host_model_inst.wr(16'h3899, 8'hf5);
		chk(16'({cfg.columnLineStop, cfg.columnLineAhead}), 16'h15);
		close_out();
	end
endmodule
`default_nettype wire
